// file: rtl/crt_baud_gate.sv
// Registered baud ticks, one per UART direction.
// Assumes wrap is a one-cycle pulse on each counter overflow.
`timescale 1ns/1ps
`default_nettype none

module crt_baud_gate
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic wrap,
  input wire logic [3:0] select,
  output logic [3:0] tick
);

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_dir
      always_ff @(posedge mclk or posedge reset)
      begin
        if (reset)
          tick[i] <= 1'b0;
        else if (clkEn)
          tick[i] <= wrap & select[i];
      end
    end
  endgenerate

endmodule

`default_nettype wire

// file: rtl/crt_fall_detect.sv
// Falling-edge detector for a pin that is already synchronous to mclk.
// Assumes the pin is sampled only while the clock enable is high.
`timescale 1ns/1ps
`default_nettype none

module crt_fall_detect
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic pin,
  output logic fall
);

  logic pinPrev;

  // Reset high, so a pin already low at release reads as a falling edge
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      pinPrev <= 1'b1;
    else if (clkEn)
      pinPrev <= pin;
  end

  assign fall = pinPrev & ~pin;

endmodule

`default_nettype wire

// file: rtl/crt_params.svh
// Offsets, field positions and reset values of the capture/reload timer.
// Assumes an 8-bit register port with a 3-bit word address.
`ifndef CRT_PARAMS_SVH
`define CRT_PARAMS_SVH

`define CRT_ADDR_W 3
`define CRT_DATA_W 8
`define CRT_COUNT_W 16

`define CRT_OFF_CONTROL 3'h0
`define CRT_OFF_MODE 3'h1
`define CRT_OFF_COUNT_LOW 3'h2
`define CRT_OFF_COUNT_HIGH 3'h3
`define CRT_OFF_CAPTURE_LOW 3'h4
`define CRT_OFF_CAPTURE_HIGH 3'h5
`define CRT_OFF_RELOAD_LOW 3'h6
`define CRT_OFF_RELOAD_HIGH 3'h7

// Control register fields
`define CRT_CTL_OVF 7
`define CRT_CTL_EXF 6
`define CRT_CTL_A_RX 5
`define CRT_CTL_A_TX 4
`define CRT_CTL_EXT_EN 3
`define CRT_CTL_RUN 2
`define CRT_CTL_SRC 1
`define CRT_CTL_CAP 0

// Mode register fields
`define CRT_MOD_IRQ_EN 7
`define CRT_MOD_B_RX 5
`define CRT_MOD_B_TX 4
`define CRT_MOD_DOWN_EN 0

`define CRT_CONTROL_RESET 8'h00
`define CRT_MODE_RESET 8'h00
`define CRT_MODE_MASK 8'hB1
`define CRT_COUNT_RESET 16'h0000
`define CRT_COUNT_MAX 16'hFFFF

`endif

// file: rtl/crt_pkg.sv
// Types shared by the capture/reload timer files.
// Assumes crt_params.svh supplies the widths.
`default_nettype none
`include "crt_params.svh"

package crt_pkg;

  typedef logic [`CRT_COUNT_W-1:0] crt_count_t;
  typedef logic [`CRT_DATA_W-1:0] crt_byte_t;

  // Operating function chosen from the control and mode bits
  typedef enum logic [1:0] {
    CRT_FN_CAPTURE,
    CRT_FN_RELOAD_UP,
    CRT_FN_RELOAD_UPDOWN,
    CRT_FN_BAUD
  } crt_function_e;

endpackage

`default_nettype wire

// file: rtl/crt_timer.sv
// Capture/reload timer: 16-bit counter with capture, auto-reload
// (up or up/down) and baud generation, plus its register port.
// Assumes timerTick, countPin and trigPin are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
`include "crt_params.svh"

// Function
// - 16-bit counter, clock source selectable
// - Event mode counts count-pin falling edges
// - Run bit starts and stops counter
// - Overflow or underflow sets overflow flag, except in baud use
// - Capture without trigger: plain 16-bit timer
// - Trigger fall copies count into capture
// - Capture trigger sets external flag, counting continues
// - Either flag plus enable raises interrupt
// - Reload mode: overflow loads reload value
// - Up-only reload trigger fall reloads, sets flag
// - Up-only counts to FFFF, flags, reloads
// - Trigger pin high up, low down
// - Up/down overflow at FFFF reloads, flags
// - Down count underflows when equal reload
// - Underflow loads FFFF, sets overflow flag
// - Up/down: external flag toggles, no interrupt
// - Any clock select makes baud generator
module crt_timer
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic timerTick,
  input wire logic countPin,
  input wire logic trigPin,
  input wire logic [`CRT_ADDR_W-1:0] addr,
  input wire logic [`CRT_DATA_W-1:0] wdata,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [`CRT_DATA_W-1:0] rdata,
  output logic irq,
  output logic uartATxTick,
  output logic uartARxTick,
  output logic uartBTxTick,
  output logic uartBRxTick
);

  crt_pkg::crt_byte_t control;
  crt_pkg::crt_byte_t mode;
  crt_pkg::crt_count_t count;
  crt_pkg::crt_count_t capture;
  crt_pkg::crt_count_t reload;
  crt_pkg::crt_function_e func;
  crt_pkg::crt_count_t next_count;
  logic trigFall;
  logic countFall;
  logic baudSel;
  logic step;
  logic countUp;
  logic wrap;
  logic trigEvent;
  logic ovfSet;
  logic exfSet;
  logic exfToggle;
  logic [3:0] baudTicks;

  crt_fall_detect u_trig_edge
  (
    .mclk(mclk),
    .reset(reset),
    .clkEn(clkEn),
    .pin(trigPin),
    .fall(trigFall)
  );

  crt_fall_detect u_count_edge
  (
    .mclk(mclk),
    .reset(reset),
    .clkEn(clkEn),
    .pin(countPin),
    .fall(countFall)
  );

  // Function decode
  assign baudSel = control[`CRT_CTL_A_RX] | control[`CRT_CTL_A_TX]
    | mode[`CRT_MOD_B_RX] | mode[`CRT_MOD_B_TX];

  always_comb
  begin
    if (baudSel)
      func = crt_pkg::CRT_FN_BAUD;
    else if (control[`CRT_CTL_CAP])
      func = crt_pkg::CRT_FN_CAPTURE;
    else if (mode[`CRT_MOD_DOWN_EN])
      func = crt_pkg::CRT_FN_RELOAD_UPDOWN;
    else
      func = crt_pkg::CRT_FN_RELOAD_UP;
  end

  // Count step gated by run bit, from tick or pin edge
  assign step = control[`CRT_CTL_RUN]
    & (control[`CRT_CTL_SRC] ? countFall : timerTick);

  // Pin sets direction only in up/down reload
  assign countUp = (func != crt_pkg::CRT_FN_RELOAD_UPDOWN) | trigPin;

  // Overflow at all ones going up, equality with reload going down
  assign wrap = step & (countUp ? (count == `CRT_COUNT_MAX)
    : (count == reload));

  // In up/down the pin is a direction, so its edges never trigger
  assign trigEvent = control[`CRT_CTL_EXT_EN] & trigFall
    & (func != crt_pkg::CRT_FN_RELOAD_UPDOWN);

  always_comb
  begin
    next_count = count;
    if (trigEvent && (func == crt_pkg::CRT_FN_RELOAD_UP))
      next_count = reload;
    else if (wrap && !countUp)
      next_count = `CRT_COUNT_MAX;
    else if (wrap && (func == crt_pkg::CRT_FN_CAPTURE))
      next_count = `CRT_COUNT_RESET;
    else if (wrap)
      next_count = reload;
    else if (step && countUp)
      next_count = count + 16'h0001;
    else if (step)
      next_count = count - 16'h0001;
  end

  // Software write to a count byte beats the hardware step
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      count <= `CRT_COUNT_RESET;
    else if (clkEn)
    begin
      if (wrStb && addr == `CRT_OFF_COUNT_LOW)
        count <= {next_count[15:8], wdata};
      else if (wrStb && addr == `CRT_OFF_COUNT_HIGH)
        count <= {wdata, next_count[7:0]};
      else
        count <= next_count;
    end
  end

  // Capture registers; a trigger edge beats a software write
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      capture <= `CRT_COUNT_RESET;
    else if (clkEn)
    begin
      if (trigEvent && func == crt_pkg::CRT_FN_CAPTURE)
        capture <= count;
      else if (wrStb && addr == `CRT_OFF_CAPTURE_LOW)
        capture[7:0] <= wdata;
      else if (wrStb && addr == `CRT_OFF_CAPTURE_HIGH)
        capture[15:8] <= wdata;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      reload <= `CRT_COUNT_RESET;
    else if (clkEn)
    begin
      if (wrStb && addr == `CRT_OFF_RELOAD_LOW)
        reload[7:0] <= wdata;
      else if (wrStb && addr == `CRT_OFF_RELOAD_HIGH)
        reload[15:8] <= wdata;
    end
  end

  // Flag events; baud use never sets the overflow flag
  assign ovfSet = wrap & (func != crt_pkg::CRT_FN_BAUD);
  assign exfSet = trigEvent;
  assign exfToggle = wrap & (func == crt_pkg::CRT_FN_RELOAD_UPDOWN);

  // Control register: hardware events win over a same-cycle write
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      control <= `CRT_CONTROL_RESET;
    else if (clkEn)
    begin
      if (wrStb && addr == `CRT_OFF_CONTROL)
        control <= wdata;
      if (ovfSet)
        control[`CRT_CTL_OVF] <= 1'b1;
      if (exfToggle)
        control[`CRT_CTL_EXF] <= ~control[`CRT_CTL_EXF];
      else if (exfSet)
        control[`CRT_CTL_EXF] <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      mode <= `CRT_MODE_RESET;
    else if (clkEn && wrStb && addr == `CRT_OFF_MODE)
      mode <= wdata & `CRT_MODE_MASK;
  end

  // External flag is a count bit in up/down and raises no request
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      irq <= 1'b0;
    else if (clkEn)
      irq <= mode[`CRT_MOD_IRQ_EN] & (control[`CRT_CTL_OVF]
        | (control[`CRT_CTL_EXF]
        & (func != crt_pkg::CRT_FN_RELOAD_UPDOWN)));
  end

  // Read data valid only the cycle after the strobe
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      rdata <= 8'h00;
    else if (clkEn)
    begin
      if (!rdStb)
        rdata <= 8'h00;
      else
      begin
        case (addr)
          `CRT_OFF_CONTROL: rdata <= control;
          `CRT_OFF_MODE: rdata <= mode;
          `CRT_OFF_COUNT_LOW: rdata <= count[7:0];
          `CRT_OFF_COUNT_HIGH: rdata <= count[15:8];
          `CRT_OFF_CAPTURE_LOW: rdata <= capture[7:0];
          `CRT_OFF_CAPTURE_HIGH: rdata <= capture[15:8];
          `CRT_OFF_RELOAD_LOW: rdata <= reload[7:0];
          `CRT_OFF_RELOAD_HIGH: rdata <= reload[15:8];
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

  crt_baud_gate u_baud
  (
    .mclk(mclk),
    .reset(reset),
    .clkEn(clkEn),
    .wrap(wrap),
    .select({mode[`CRT_MOD_B_RX], mode[`CRT_MOD_B_TX],
      control[`CRT_CTL_A_RX], control[`CRT_CTL_A_TX]}),
    .tick(baudTicks)
  );

  assign uartATxTick = baudTicks[0];
  assign uartARxTick = baudTicks[1];
  assign uartBTxTick = baudTicks[2];
  assign uartBRxTick = baudTicks[3];

endmodule

`default_nettype wire

// file: test/crt_pin_model.sv
// Far-side pins: trigger/direction level and event count pulses.
// Assumes bench commands change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module crt_pin_model
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic trigLevel,
  input wire logic countReq,
  output logic trigPin,
  output logic countPin
);
  // Level held between edges, high = up
  always_ff @(posedge mclk or posedge reset)
    if (reset)
      trigPin <= 1'b1;
    else
      trigPin <= trigLevel;
  // One low cycle per event; idles high as if pulled up
  always_ff @(posedge mclk or posedge reset)
    if (reset)
      countPin <= 1'b1;
    else
      countPin <= !countReq;
endmodule
`default_nettype wire

// file: test/crt_timer_assertions.sv
// Port checker for crt_timer; shadows software-owned control bits.
// Assumes bound to crt_timer; no strobes while clkEn is low.
`timescale 1ns/1ps
`default_nettype none
module crt_timer_assertions
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic uartATxTick,
  input wire logic uartARxTick,
  input wire logic uartBTxTick,
  input wire logic uartBRxTick
);
  logic [7:0] ctl;
  logic [7:0] mode;
  // Flag bits here are stale; only select, run and enable bits are trusted
  always_ff @(posedge mclk or posedge reset)
    if (reset)
    begin
      ctl <= 8'h00;
      mode <= 8'h00;
    end
    else if (wrStb)
    begin
      if (addr == 3'h0)
        ctl <= wdata;
      if (addr == 3'h1)
        mode <= wdata;
    end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  read_idle_a: assert property (
    !$past(rdStb) |-> rdata == 8'h00)
    else $error("rdata not idle");
  mode_spare_a: assert property (
    $past(rdStb) && $past(addr) == 3'h1 |-> (rdata & 8'h4E) == 8'h00)
    else $error("spare mode bits set");
  irq_mask_a: assert property (irq |-> $past(mode[7]))
    else $error("irq while disabled");
  stop_quiet_a: assert property (
    !ctl[2] [*4] |-> !(uartATxTick | uartARxTick | uartBTxTick | uartBRxTick))
    else $error("tick while stopped");
  a_tx_sel_a: assert property (
    uartATxTick |-> $past(ctl[4]) || $past(ctl[4], 2))
    else $error("A tx tick unselected");
  a_rx_sel_a: assert property (
    uartARxTick |-> $past(ctl[5]) || $past(ctl[5], 2))
    else $error("A rx tick unselected");
  b_tx_sel_a: assert property (
    uartBTxTick |-> $past(mode[4]) || $past(mode[4], 2))
    else $error("B tx tick unselected");
  b_rx_sel_a: assert property (
    uartBRxTick |-> $past(mode[5]) || $past(mode[5], 2))
    else $error("B rx tick unselected");
endmodule
`default_nettype wire

// file: test/crt_timer_tb_top.sv
// Self-checking bench for crt_timer with the far-side pin model.
// Assumes checker and pin model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
bind crt_timer crt_timer_assertions crt_timer_assertions_i (.mclk, .reset,
  .addr, .wdata, .wrStb, .rdStb, .rdata, .irq, .uartATxTick, .uartARxTick,
  .uartBTxTick, .uartBRxTick);
module crt_timer_tb_top;
  logic mclk = 1'b0, reset = 1'b1, timerTick = 1'b1, trigLevel = 1'b1;
  logic countReq = 1'b0, wrStb = 1'b0, rdStb = 1'b0;
  logic clkEn = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic irq, trigPin, countPin;
  logic [3:0] tick;
  int errors = 0, samples_checked = 0, cyc = 0;
  int nt[4] = '{0, 0, 0, 0};
  crt_timer crt_timer_i (.mclk, .reset, .clkEn, .timerTick, .countPin,
    .trigPin, .addr, .wdata, .wrStb, .rdStb, .rdata, .irq,
    .uartATxTick(tick[0]), .uartARxTick(tick[1]), .uartBTxTick(tick[2]),
    .uartBRxTick(tick[3]));
  crt_pin_model crt_pin_model_i (.mclk, .reset, .trigLevel, .countReq,
    .trigPin, .countPin);
  initial
  begin
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    for (int i = 0; i < 4; i++)
      nt[i] += int'(tick[i] === 1'b1);
    if (cyc == 3000)
    begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobes stay up until the next call, so back-to-back cycles work
  task automatic bus(input logic w, input logic r, input logic [2:0] a,
    input logic [7:0] d);
    wrStb <= w;
    rdStb <= r;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic wr16(input logic [2:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 3'h1, d[15:8]);
  endtask
  // Sampled at the next edge, before that edge's updates land
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic reload_wrap();
    wr16(3'h6, 16'hFFFE);
    wr16(3'h2, 16'hFFFF);
    wr(3'h1, 8'h80);
    wr(3'h0, 8'h04);
    wr(3'h0, 8'h00);
    rd(3'h2, 8'hFE);
    rd(3'h3, 8'hFF);
    rd(3'h0, 8'h80);
    chk({15'h0, irq}, 16'h0001);
    wr(3'h0, 8'h00);
    rd(3'h0, 8'h00);
    chk({15'h0, irq}, 16'h0000);
  endtask
  task automatic capture_trig();
    timerTick <= 1'b0;
    wr16(3'h2, 16'h1234);
    wr(3'h0, 8'h0D);
    trigLevel <= 1'b0;
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    rd(3'h4, 8'h34);
    rd(3'h5, 8'h12);
    rd(3'h0, 8'h4D);
    rd(3'h2, 8'h34);
    wr(3'h0, 8'h00);
  endtask
  task automatic up_down();
    wr(3'h1, 8'h01);
    wr16(3'h6, 16'h0005);
    wr16(3'h2, 16'h0006);
    timerTick <= 1'b1;
    wr(3'h0, 8'h04);
    wr(3'h0, 8'h04);
    wr(3'h0, 8'h00);
    rd(3'h2, 8'hFF);
    rd(3'h3, 8'hFF);
    rd(3'h0, 8'hC0);
    wr(3'h0, 8'h00);
    trigLevel <= 1'b1;
    wr(3'h0, 8'h04);
    wr(3'h0, 8'h00);
    rd(3'h2, 8'h05);
    rd(3'h0, 8'hC0);
    wr(3'h1, 8'h81);
    wr(3'h0, 8'h40);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    chk({15'h0, irq}, 16'h0000);
    wr(3'h1, 8'h80);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    chk({15'h0, irq}, 16'h0001);
  endtask
  task automatic event_count();
    wr(3'h1, 8'h00);
    wr16(3'h2, 16'h0000);
    wr(3'h0, 8'h06);
    repeat (3)
    begin
      countReq <= 1'b1;
      bus(1'b0, 1'b0, 3'h0, 8'h00);
      countReq <= 1'b0;
      bus(1'b0, 1'b0, 3'h0, 8'h00);
    end
    wr(3'h0, 8'h00);
    rd(3'h2, 8'h03);
  endtask
  task automatic trig_reload();
    timerTick <= 1'b0;
    wr16(3'h6, 16'hABCD);
    wr16(3'h2, 16'h0010);
    wr(3'h0, 8'h0C);
    trigLevel <= 1'b0;
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    rd(3'h2, 8'hCD);
    rd(3'h3, 8'hAB);
    rd(3'h0, 8'h4C);
    trigLevel <= 1'b1;
    wr(3'h0, 8'h00);
    wr16(3'h2, 16'hFFFF);
    wr(3'h0, 8'h05);
    timerTick <= 1'b1;
    wr(3'h0, 8'h01);
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h00);
    rd(3'h0, 8'h81);
    wr(3'h0, 8'h00);
  endtask
  // Five frozen cycles must not step; only the one enabled cycle counts
  task automatic hold_enable();
    wr16(3'h2, 16'h0040);
    wr(3'h0, 8'h04);
    clkEn <= 1'b0;
    repeat (5) bus(1'b0, 1'b0, 3'h0, 8'h00);
    clkEn <= 1'b1;
    wr(3'h0, 8'h00);
    rd(3'h2, 8'h41);
    rd(3'h3, 8'h00);
  endtask
  task automatic baud();
    chk(16'(nt[0] + nt[1] + nt[2] + nt[3]), 16'h0000);
    wr16(3'h6, 16'hFFFE);
    wr16(3'h2, 16'hFFFE);
    wr(3'h1, 8'h20);
    wr(3'h0, 8'h14);
    repeat (20) bus(1'b0, 1'b0, 3'h0, 8'h00);
    wr(3'h0, 8'h00);
    repeat (4) bus(1'b0, 1'b0, 3'h0, 8'h00);
    chk(16'(nt[0] != 0), 16'h0001);
    chk(16'(nt[0]), 16'(nt[3]));
    chk(16'(nt[0]), 16'h000A);
    chk(16'(nt[3]), 16'h000A);
    chk(16'(nt[1] + nt[2]), 16'h0000);
    rd(3'h0, 8'h00);
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    reload_wrap();
    capture_trig();
    up_down();
    event_count();
    trig_reload();
    hold_enable();
    baud();
    test_done();
  end
endmodule
`default_nettype wire
